// >>> rtl/cfg_loader_pkg.sv
// constants, field layouts and carrier types of the configuration loader
// assumes one 40 MHz core clock; shared by the loader and its byte fetcher
package cfg_loader_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int SLOW_HZ = 100_000;
   localparam int FAST_HZ = 400_000;
   // prescaler counts a quarter of a serial clock period
   localparam int PRESC_SLOW = CLK_HZ / (4 * SLOW_HZ);
   localparam int PRESC_FAST = CLK_HZ / (4 * FAST_HZ);
   localparam int PRESC_W = 16;

   // own register map, byte addresses
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SWITCH_CONTROL_REG = 8'h08;
   localparam logic [7:0] OFS_PRESC = 8'h0C;

   // control register fields
   localparam int CTRL_IGNORE_SUM = 0;
   // status register fields
   localparam int ST_DONE = 0;
   localparam int ST_CONTENT = 1;
   localparam int ST_NACK = 2;
   localparam int ST_ARB = 3;
   localparam int ST_MISC = 4;
   localparam int ST_UNMAPPED = 5;
   localparam int ST_BUSY = 6;
   localparam int ST_W1C_BITS = 6;
   // switch control field
   localparam int SWITCH_CONTROL_REG_HALT = 0;

   // configuration block layout
   localparam logic [1:0] TYPE_SINGLE = 2'h0;
   localparam logic [1:0] TYPE_SEQ = 2'h1;
   localparam logic [1:0] TYPE_BAD = 2'h2;
   localparam logic [1:0] TYPE_DONE = 2'h3;
   localparam logic [2:0] POS_ADDR_LO = 3'h0;
   localparam logic [2:0] POS_TYPE = 3'h1;
   localparam logic [2:0] POS_DATA_SEQ = 3'h4;
   localparam logic [7:0] SUM_GOOD = 8'hFF;
   localparam logic [15:0] EE_LAST = 16'hFFFF;
   localparam logic [2:0] EE_DEV_FIXED = 3'b101;
   localparam logic [15:0] HALF_ZERO = 16'h0000;
   localparam int ARB_LIMIT = 16;

   typedef enum logic [1:0] {HT_IDLE, HT_BUSY, HT_NONSEQ, HT_SEQ} htrans_t;

   typedef enum {S_IDLE, S_ASK, S_WAIT, S_WRITE} load_state_t;

   // one answer of the two-wire master engine per attempted byte read
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic nack;
      logic arb_lost;
      logic misplaced;
   } smb_rsp_t;

   // full doubleword write into configuration space
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [31:0] data;
   } cfg_wr_t;
endpackage

// >>> rtl/ee_byte_fetch.sv
// fetches one eeprom byte through the two-wire master engine, retrying
// on lost arbitration; assumes the engine answers each request once
`timescale 1ns/1ps
module ee_byte_fetch
   import cfg_loader_pkg::*;
#(
   parameter int ARB_MAX = ARB_LIMIT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic go,
   output logic busy,
   output logic smb_req,
   input wire smb_rsp_t smb_rsp,
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic err_nack,
   output logic err_arb,
   output logic err_misc
);
   if (ARB_MAX < 1 || ARB_MAX > 255) begin
      $error("ARB_MAX out of range");
   end

   logic wait_q, wait_d;
   logic retry_q;
   logic [7:0] arb_cnt_q, arb_cnt_d;
   logic [7:0] data_q;
   logic ok_q, nack_q, arb_q, misc_q;

   wire logic got = wait_q && smb_rsp.valid;
   wire logic lost = got && smb_rsp.arb_lost;
   wire logic arb_full = lost && (arb_cnt_q == 8'(ARB_MAX - 1));
   wire logic good = got && !smb_rsp.arb_lost && !smb_rsp.nack && !smb_rsp.misplaced;
   wire logic finish = got && !(lost && !arb_full);

   assign busy = wait_q || retry_q;
   assign smb_req = go || retry_q;
   assign byte_valid = ok_q;
   assign byte_data = data_q;
   assign err_nack = nack_q;
   assign err_arb = arb_q;
   assign err_misc = misc_q;

   always_comb begin
      wait_d = wait_q;
      if (smb_req) begin
         wait_d = 1'b1;
      end else if (finish) begin
         wait_d = 1'b0;
      end
      arb_cnt_d = arb_cnt_q;
      if (go || good) begin
         arb_cnt_d = 8'h00;
      end else if (lost) begin
         arb_cnt_d = arb_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_q <= 1'b0;
         retry_q <= 1'b0;
         arb_cnt_q <= 8'h00;
         data_q <= 8'h00;
         ok_q <= 1'b0;
         nack_q <= 1'b0;
         arb_q <= 1'b0;
         misc_q <= 1'b0;
      end else begin
         wait_q <= wait_d;
         retry_q <= lost && !arb_full;
         arb_cnt_q <= arb_cnt_d;
         if (good) begin
            data_q <= smb_rsp.data;
         end
         ok_q <= good;
         nack_q <= got && smb_rsp.nack && !smb_rsp.arb_lost;
         arb_q <= arb_full;
         misc_q <= got && smb_rsp.misplaced && !smb_rsp.nack && !smb_rsp.arb_lost;
      end
   end
endmodule

// >>> rtl/eeprom_config_loader.sv
// boot-time loader: parses configuration blocks read from a serial eeprom
// and writes doublewords into configuration space; AHB-Lite register slave
// assumes an external two-wire master engine and a target address decoder
// Function
// - read bytes in order from address zero; stop at done block end or wrap.
// - target byte address is space base plus offset; any register accepted.
// - byte address is the stored doubleword address with two zero bits below.
// - every register update is one full 32-bit doubleword write.
// - single block is six bytes: address low, type plus address high, data LSB first.
// - type 0 writes its one data doubleword to the given address.
// - type 1 reads a count then writes that many doublewords at rising addresses.
// - type 3 is the done block with checksum; its end ends loading.
// - write to an undefined register is dropped and sets the unmapped flag.
// - clear 8-bit sum at start, add each byte; good image gives 0xFF.
// - with ignore-checksum set, a sum mismatch is no error.
// - any error stops loading, sets halt-after-reset and records its cause.
// - load complete flag sets on normal finish and on error abort.
// - checksum mismatch sets content error, halt, abort and done.
// - address wrap before done block sets content error, halt, abort, done.
// - type 2 is invalid: content error, halt, abort and done.
// - unexpected nack sets nack error, halt, abort and done.
// - sixteen consecutive arbitration losses set lost-arbitration error and abort.
// - misplaced start or stop sets misc error, halt, abort and done.
// - device address is 101 followed by the four select pins.
// - loading runs in fundamental or hot reset when the mode selects it.
// - prescaler set for 100 KHz with slow pin asserted, else 400 KHz.
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
module eeprom_config_loader
   import cfg_loader_pkg::*;
#(
   parameter int MODE_W = 4,
   parameter logic [15:0] EE_LOAD_MODES = 16'h0001
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic reset_load_req,
   input wire logic [MODE_W-1:0] switch_operating_mode,
   input wire logic master_slow_mode_pin,
   input wire logic [4:1] eeprom_addr_select_pins,
   output logic [7:1] eeprom_dev_addr,
   output logic [PRESC_W-1:0] master_clock_prescaler,
   output logic smb_req,
   output logic [15:0] smb_mem_addr,
   input wire smb_rsp_t smb_rsp,
   output cfg_wr_t cfg_wr,
   input wire logic cfg_wr_mapped,
   output logic halt_after_reset_bit,
   output logic loading
);
   if (MODE_W < 1 || MODE_W > 4) begin
      $error("MODE_W out of range");
   end

   // register bus
   logic wr_pend_q;
   logic [7:0] wr_ofs_q;
   logic [31:0] rdata_q;
   logic ignore_sum_check_bit;
   logic [ST_W1C_BITS-1:0] status_q, status_d;
   logic halt_q, halt_d;
   logic [PRESC_W-1:0] presc_q;
   logic strap_done_q;

   // loader
   load_state_t st_q, st_d;
   logic [15:0] ee_addr_q, ee_addr_d;
   logic [2:0] pos_q, pos_d;
   logic [1:0] type_q, type_d;
   logic [13:0] dword_target_address, taddr_d;
   logic [15:0] dword_count, cnt_d;
   logic [31:0] data_q, data_d;
   logic [7:0] sum_q, sum_d;
   logic [ST_W1C_BITS-1:0] ev_set;
   logic abort_ev;
   logic fetch_go;
   logic fetch_busy;
   logic byte_valid;
   logic [7:0] byte_data;
   logic err_nack, err_arb, err_misc;

   ee_byte_fetch #(
      .ARB_MAX(ARB_LIMIT)
   ) u_fetch (
      .hclk(hclk),
      .hresetn(hresetn),
      .go(fetch_go),
      .busy(fetch_busy),
      .smb_req(smb_req),
      .smb_rsp(smb_rsp),
      .byte_valid(byte_valid),
      .byte_data(byte_data),
      .err_nack(err_nack),
      .err_arb(err_arb),
      .err_misc(err_misc)
   );

   // bus decode: zero-wait slave, always OKAY
   wire logic addr_phase = hsel && hready && (htrans == HT_NONSEQ || htrans == HT_SEQ);
   wire logic [7:0] ofs = haddr[7:0];
   wire logic ofs_hit = (haddr[31:8] == 24'h00_0000);
   wire logic wr_ctrl = wr_pend_q && wr_ofs_q == OFS_CTRL;
   wire logic wr_status = wr_pend_q && wr_ofs_q == OFS_STATUS;
   wire logic wr_switch_control_reg = wr_pend_q && wr_ofs_q == OFS_SWITCH_CONTROL_REG;
   wire logic wr_presc = wr_pend_q && wr_ofs_q == OFS_PRESC;
   wire logic busy_now = (st_q != S_IDLE);
   wire logic [31:0] ctrl_rd = {31'h0000_0000, ignore_sum_check_bit};
   wire logic [31:0] two_wire_status_reg = {25'h000_0000, busy_now, status_q};
   wire logic [31:0] switch_control_reg = {31'h0000_0000, halt_q};
   wire logic [31:0] presc_rd = {16'h0000, presc_q};
   wire logic [31:0] rd_mux = !ofs_hit ? 32'h0000_0000 :
                              (ofs == OFS_CTRL) ? ctrl_rd :
                              (ofs == OFS_STATUS) ? two_wire_status_reg :
                              (ofs == OFS_SWITCH_CONTROL_REG) ? switch_control_reg :
                              (ofs == OFS_PRESC) ? presc_rd : 32'h0000_0000;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign eeprom_dev_addr = {EE_DEV_FIXED, eeprom_addr_select_pins};
   assign master_clock_prescaler = presc_q;
   assign smb_mem_addr = ee_addr_q;
   assign halt_after_reset_bit = halt_q;
   assign loading = busy_now;

   // start only on a reset whose mode includes eeprom loading
   wire logic mode_sel = EE_LOAD_MODES[4'(switch_operating_mode)];
   wire logic start = (st_q == S_IDLE) && reset_load_req && mode_sel;

   // byte parsing
   wire logic [7:0] sum_next = sum_q + byte_data;
   wire logic [1:0] type_in = byte_data[7:6];
   wire logic at_last = (ee_addr_q == EE_LAST);
   wire logic is_single = (type_q == TYPE_SINGLE);
   wire logic in_data = is_single ? (pos_q >= 3'h2) : (pos_q >= POS_DATA_SEQ);
   wire logic [1:0] lane = is_single ? (pos_q[1:0] - 2'h2) : pos_q[1:0];
   wire logic done_blk = (pos_q == POS_TYPE) && (type_in == TYPE_DONE);
   wire logic sum_bad = (sum_next != SUM_GOOD) && !ignore_sum_check_bit;
   wire logic seq_cnt_zero = (pos_q == 3'h3) && !is_single &&
                             ({byte_data, dword_count[7:0]} == HALF_ZERO);

   always_comb begin
      st_d = st_q;
      ee_addr_d = ee_addr_q;
      pos_d = pos_q;
      type_d = type_q;
      taddr_d = dword_target_address;
      cnt_d = dword_count;
      data_d = data_q;
      sum_d = sum_q;
      ev_set = '0;
      abort_ev = 1'b0;
      fetch_go = 1'b0;
      cfg_wr = '0;
      unique case (st_q)
         S_IDLE: begin
            if (start) begin
               st_d = S_ASK;
               ee_addr_d = HALF_ZERO;
               pos_d = POS_ADDR_LO;
               sum_d = 8'h00;
            end
         end
         S_ASK: begin
            if (!fetch_busy) begin
               fetch_go = 1'b1;
               st_d = S_WAIT;
            end
         end
         S_WAIT: begin
            if (err_nack || err_arb || err_misc) begin
               ev_set[ST_NACK] = err_nack;
               ev_set[ST_ARB] = err_arb;
               ev_set[ST_MISC] = err_misc;
               abort_ev = 1'b1;
            end else if (byte_valid) begin
               sum_d = sum_next;
               ee_addr_d = ee_addr_q + 16'h0001;
               st_d = S_ASK;
               pos_d = pos_q + 3'h1;
               unique case (pos_q)
                  POS_ADDR_LO: taddr_d[7:0] = byte_data;
                  POS_TYPE: begin
                     type_d = type_in;
                     taddr_d[13:8] = byte_data[5:0];
                  end
                  default: begin
                     if (in_data) begin
                        data_d[8*lane +: 8] = byte_data;
                     end else if (pos_q == 3'h2) begin
                        cnt_d[7:0] = byte_data;
                     end else begin
                        cnt_d[15:8] = byte_data;
                     end
                  end
               endcase
               if (done_blk) begin
                  ev_set[ST_DONE] = 1'b1;
                  if (sum_bad) begin
                     ev_set[ST_CONTENT] = 1'b1;
                     abort_ev = 1'b1;
                  end else begin
                     st_d = S_IDLE;
                  end
               end else if ((pos_q == POS_TYPE) && (type_in == TYPE_BAD)) begin
                  ev_set[ST_CONTENT] = 1'b1;
                  abort_ev = 1'b1;
               end else if (at_last) begin
                  ev_set[ST_CONTENT] = 1'b1;
                  abort_ev = 1'b1;
               end else if (seq_cnt_zero) begin
                  pos_d = POS_ADDR_LO;
               end else if (in_data && lane == 2'h3) begin
                  st_d = S_WRITE;
               end
            end
         end
         S_WRITE: begin
            cfg_wr.valid = 1'b1;
            cfg_wr.addr = {dword_target_address, 2'b00};
            cfg_wr.data = data_q;
            ev_set[ST_UNMAPPED] = !cfg_wr_mapped;
            st_d = S_ASK;
            if (is_single) begin
               pos_d = POS_ADDR_LO;
            end else begin
               taddr_d = dword_target_address + 14'h0001;
               cnt_d = dword_count - 16'h0001;
               pos_d = (dword_count == 16'h0001) ? POS_ADDR_LO : POS_DATA_SEQ;
            end
         end
      endcase
      if (abort_ev) begin
         ev_set[ST_DONE] = 1'b1;
         st_d = S_IDLE;
      end
   end

   // status: write one to clear, a same-cycle event wins
   always_comb begin
      status_d = status_q;
      if (wr_status) begin
         status_d = status_q & ~hwdata[ST_W1C_BITS-1:0];
      end
      if (start) begin
         status_d[ST_DONE] = 1'b0;
      end
      status_d = status_d | ev_set;
      halt_d = halt_q;
      if (wr_switch_control_reg) begin
         halt_d = hwdata[SWITCH_CONTROL_REG_HALT];
      end
      if (abort_ev) begin
         halt_d = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_phase && hwrite && ofs_hit;
         wr_ofs_q <= ofs;
         if (addr_phase && !hwrite) begin
            rdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ignore_sum_check_bit <= 1'b0;
         status_q <= '0;
         halt_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ignore_sum_check_bit <= hwdata[CTRL_IGNORE_SUM];
         end
         status_q <= status_d;
         halt_q <= halt_d;
      end
   end

   // slow-mode strap caught at the first edge after release, not in reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_done_q <= 1'b0;
         presc_q <= PRESC_W'(PRESC_FAST);
      end else begin
         strap_done_q <= 1'b1;
         if (!strap_done_q) begin
            presc_q <= master_slow_mode_pin ? PRESC_W'(PRESC_SLOW) :
                       PRESC_W'(PRESC_FAST);
         end else if (wr_presc) begin
            presc_q <= hwdata[PRESC_W-1:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= S_IDLE;
         ee_addr_q <= HALF_ZERO;
         pos_q <= POS_ADDR_LO;
         type_q <= TYPE_SINGLE;
         dword_target_address <= 14'h0000;
         dword_count <= HALF_ZERO;
         data_q <= 32'h0000_0000;
         sum_q <= 8'h00;
      end else begin
         st_q <= st_d;
         ee_addr_q <= ee_addr_d;
         pos_q <= pos_d;
         type_q <= type_d;
         dword_target_address <= taddr_d;
         dword_count <= cnt_d;
         data_q <= data_d;
         sum_q <= sum_d;
      end
   end
endmodule

// >>> bench/cfg_loader_props.sv
// port-level checker for the eeprom configuration loader
// bound into every eeprom_config_loader; single hclk domain
`timescale 1ns/1ps
module cfg_loader_props
   import cfg_loader_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic master_slow_mode_pin,
   input wire logic [4:1] eeprom_addr_select_pins,
   input wire logic [7:1] eeprom_dev_addr,
   input wire logic [PRESC_W-1:0] master_clock_prescaler,
   input wire logic smb_req,
   input wire logic [15:0] smb_mem_addr,
   input wire smb_rsp_t smb_rsp,
   input wire cfg_wr_t cfg_wr,
   input wire logic halt_after_reset_bit,
   input wire logic loading
);
   logic [15:0] last_q;
   logic [4:0] lost_q;
   // last requested byte, parked at all ones so the first request must be zero or all ones
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn || !loading) last_q <= 16'hFFFF;
      else if (smb_req) last_q <= smb_mem_addr;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn || !loading) lost_q <= 5'h00;
      else if (smb_rsp.valid) lost_q <= smb_rsp.arb_lost ? lost_q + 5'h01 : 5'h00;
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   dev_addr_a:
   assert property (eeprom_dev_addr == {EE_DEV_FIXED, eeprom_addr_select_pins})
      else $error("eeprom device address wrong");
   presc_init_a:
   assert property ($rose(hresetn) |=> master_clock_prescaler ==
      PRESC_W'($past(master_slow_mode_pin) ? PRESC_SLOW : PRESC_FAST))
      else $error("prescaler not set from slow strap");
   req_order_a:
   assert property (smb_req |-> smb_mem_addr == last_q || smb_mem_addr == last_q + 16'h0001)
      else $error("eeprom bytes not read in sequence");
   req_loading_a:
   assert property (smb_req |-> loading) else $error("read issued while not loading");
   wr_single_a:
   assert property (cfg_wr.valid |-> loading ##1 !cfg_wr.valid)
      else $error("config write outside load or held");
   halt_abort_a:
   assert property ($rose(halt_after_reset_bit) |-> $fell(loading))
      else $error("halt set without abort");
   nack_abort_a:
   assert property (smb_rsp.valid && loading && smb_rsp.nack && !smb_rsp.arb_lost
      |-> ##[1:3] !loading) else $error("nack did not abort");
   misc_abort_a:
   assert property (smb_rsp.valid && loading && smb_rsp.misplaced && !smb_rsp.nack
      && !smb_rsp.arb_lost |-> ##[1:3] !loading) else $error("misplaced start did not abort");
   arb_retry_a:
   assert property (smb_req |-> lost_q < 5'h10) else $error("retry after sixteen losses");
   arb_abort_a:
   assert property (lost_q == 5'h10 |-> ##[0:3] !loading) else $error("arbitration abort late");
endmodule
bind eeprom_config_loader cfg_loader_props u_props (.hclk, .hresetn, .master_slow_mode_pin,
   .eeprom_addr_select_pins, .eeprom_dev_addr, .master_clock_prescaler, .smb_req,
   .smb_mem_addr, .smb_rsp, .cfg_wr, .halt_after_reset_bit, .loading);

// >>> bench/ee_engine_model.sv
// two-wire engine plus 64 KB eeprom image and target decoder
// faults hit only the byte at fault_addr; idle data toggles every cycle
`timescale 1ns/1ps
module ee_engine_model
   import cfg_loader_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic smb_req,
   input wire logic [15:0] smb_mem_addr,
   output smb_rsp_t smb_rsp,
   input wire cfg_wr_t cfg_wr,
   output logic cfg_wr_mapped,
   input wire logic [1:0] fault,
   input wire logic [15:0] fault_addr,
   input wire logic [4:0] arb_n,
   input wire logic [3:0] lat
);
   logic [7:0] mem [0:65535];
   logic [15:0] a_q;
   logic [3:0] cnt_q;
   logic pend_q;
   logic [4:0] lost_q;
   logic hit;
   assign hit = a_q == fault_addr;
   assign cfg_wr_mapped = cfg_wr.addr[15:14] != 2'b11;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         smb_rsp <= '0;
         pend_q <= 1'b0;
         cnt_q <= 4'h0;
         lost_q <= 5'h00;
         a_q <= 16'h0000;
      end else begin
         smb_rsp.valid <= 1'b0;
         smb_rsp.nack <= 1'b0;
         smb_rsp.arb_lost <= 1'b0;
         smb_rsp.misplaced <= 1'b0;
         smb_rsp.data <= ~smb_rsp.data;
         if (smb_req) begin
            pend_q <= 1'b1;
            cnt_q <= lat;
            a_q <= smb_mem_addr;
            if (smb_mem_addr != a_q) lost_q <= 5'h00;
         end else if (pend_q && cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
         else if (pend_q) begin
            pend_q <= 1'b0;
            smb_rsp.valid <= 1'b1;
            smb_rsp.data <= mem[a_q];
            if (hit && fault == 2'd3 && lost_q < arb_n) begin
               smb_rsp.arb_lost <= 1'b1;
               lost_q <= lost_q + 5'h01;
            end else begin
               lost_q <= 5'h00;
               smb_rsp.nack <= hit && fault == 2'd1;
               smb_rsp.misplaced <= hit && fault == 2'd2;
            end
         end
      end
   end
endmodule

// >>> bench/eeprom_config_loader_tb.sv
// self-checking bench: builds eeprom images, runs loads, reads status over AHB-Lite
// assumes zero-wait slave and the engine model above
`timescale 1ns/1ps
module eeprom_config_loader_tb;
   import cfg_loader_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, reset_load_req;
   logic master_slow_mode_pin, smb_req, cfg_wr_mapped, halt_after_reset_bit, loading;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, fault;
   logic [2:0] hsize;
   logic [3:0] switch_operating_mode, lat;
   logic [4:1] eeprom_addr_select_pins;
   logic [7:1] eeprom_dev_addr;
   logic [PRESC_W-1:0] master_clock_prescaler;
   logic [15:0] smb_mem_addr, fault_addr;
   logic [4:0] arb_n;
   smb_rsp_t smb_rsp;
   cfg_wr_t cfg_wr;
   int mismatches, checks_done;
   logic [7:0] img[$];
   logic [47:0] exp_wr[$], got_wr[$];
   assign hready = hreadyout;
   eeprom_config_loader dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .reset_load_req, .switch_operating_mode,
      .master_slow_mode_pin, .eeprom_addr_select_pins, .eeprom_dev_addr,
      .master_clock_prescaler, .smb_req, .smb_mem_addr, .smb_rsp, .cfg_wr, .cfg_wr_mapped,
      .halt_after_reset_bit, .loading);
   ee_engine_model ee (.hclk, .hresetn, .smb_req, .smb_mem_addr, .smb_rsp, .cfg_wr,
      .cfg_wr_mapped, .fault, .fault_addr, .arb_n, .lat);
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk)
      if (hresetn && (cfg_wr.valid && cfg_wr_mapped) === 1'b1) got_wr.push_back(cfg_wr[47:0]);
   function automatic logic [31:0] b(input int i);
      return 32'h0000_0001 << i;
   endfunction
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= HT_NONSEQ;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= HT_IDLE;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   // type 2 passes n = 0 so only its two header bytes land in the image
   function automatic void blk(logic [1:0] t, logic [13:0] a, logic [15:0] n, logic [31:0] d0);
      logic [13:0] w;
      logic [31:0] d;
      img.push_back(a[7:0]);
      img.push_back({t, a[13:8]});
      if (t == TYPE_SEQ) begin
         img.push_back(n[7:0]);
         img.push_back(n[15:8]);
      end
      for (int i = 0; i < n; i++) begin
         w = a + i[13:0];
         d = d0 + i;
         for (int k = 0; k < 4; k++) img.push_back(d[8*k+:8]);
         if (w[13:12] != 2'b11) exp_wr.push_back({w, 2'b00, d});
      end
   endfunction
   function automatic void finish(logic bad);
      logic [7:0] s;
      s = 8'hC0;
      foreach (img[i]) s += img[i];
      img.push_back(~s ^ {7'h00, bad});
      img.push_back({TYPE_DONE, 6'h00});
   endfunction
   task automatic run(input logic [31:0] st, input logic halt);
      logic [31:0] r;
      for (int i = 0; i < 65536; i++) ee.mem[i] = i < img.size() ? img[i] : 8'hFF;
      got_wr.delete();
      reset_load_req <= 1'b1;
      @(posedge hclk);
      reset_load_req <= 1'b0;
      while (loading !== 1'b1) @(posedge hclk);
      while (loading !== 1'b0) @(posedge hclk);
      bus(1'b0, OFS_STATUS, 32'h0000_0000, r);
      check(r, st);
      check(halt_after_reset_bit, halt);
      check(48'(got_wr.size()), 48'(exp_wr.size()));
      foreach (exp_wr[i]) if (i < got_wr.size()) check(got_wr[i], exp_wr[i]);
      bus(1'b1, OFS_STATUS, 32'h0000_003F, r);
      bus(1'b1, OFS_SWITCH_CONTROL_REG, 32'h0000_0000, r);
      img.delete();
      exp_wr.delete();
   endtask
   task automatic t_reset;
      logic [31:0] r;
      check(master_clock_prescaler, 48'(PRESC_SLOW));
      check(eeprom_dev_addr, {3'b101, eeprom_addr_select_pins});
      check({hreadyout, hresp}, 48'h2);
      bus(1'b1, 32'h0000_0010, 32'h0000_00FF, r);
      bus(1'b0, 32'h0000_0010, 32'h0000_0000, r);
      check(r, 48'h0);
   endtask
   task automatic t_good;
      lat <= 4'h5;
      blk(TYPE_SINGLE, 14'h0012, 16'h0001, 32'hA5A5_0001);
      blk(TYPE_SEQ, 14'h0100, 16'h0003, 32'h1234_5678);
      blk(TYPE_SINGLE, 14'h3F00, 16'h0001, 32'hDEAD_BEEF);
      finish(1'b0);
      run(b(ST_DONE) | b(ST_UNMAPPED), 1'b0);
      lat <= 4'h0;
   endtask
   task automatic t_sum;
      logic [31:0] r;
      for (int ign = 0; ign < 2; ign++) begin
         bus(1'b1, OFS_CTRL, ign, r);
         blk(TYPE_SINGLE, 14'h0021, 16'h0001, 32'h0F0F_0F0F);
         finish(1'b1);
         if (ign == 0) run(b(ST_DONE) | b(ST_CONTENT), 1'b1);
         else run(b(ST_DONE), 1'b0);
      end
      bus(1'b1, OFS_CTRL, 32'h0000_0000, r);
   endtask
   task automatic t_type2;
      blk(TYPE_BAD, 14'h0005, 16'h0000, 32'h0000_0000);
      blk(TYPE_SINGLE, 14'h0006, 16'h0001, 32'h1111_2222);
      finish(1'b0);
      exp_wr.delete();
      run(b(ST_DONE) | b(ST_CONTENT), 1'b1);
   endtask
   task automatic t_faults;
      logic [1:0] f[4] = '{2'd1, 2'd2, 2'd3, 2'd3};
      logic [4:0] n[4] = '{5'd0, 5'd0, 5'd16, 5'd15};
      int s[4] = '{ST_NACK, ST_MISC, ST_ARB, ST_DONE};
      for (int i = 0; i < 4; i++) begin
         fault <= f[i];
         fault_addr <= 16'h0003;
         arb_n <= n[i];
         blk(TYPE_SINGLE, 14'h0040, 16'h0001, 32'h5555_AAAA);
         finish(1'b0);
         if (i < 3) exp_wr.delete();
         run(b(ST_DONE) | b(s[i]), i < 3);
      end
      fault <= 2'd0;
   endtask
   task automatic t_mode;
      switch_operating_mode <= 4'h1;
      reset_load_req <= 1'b1;
      @(posedge hclk);
      reset_load_req <= 1'b0;
      repeat (20) @(posedge hclk);
      check(loading, 48'h0);
      switch_operating_mode <= 4'h0;
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #(25 * 80000);
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      {hresetn, hsel, hwrite, reset_load_req, haddr, hwdata, htrans} = '0;
      {switch_operating_mode, fault, fault_addr, arb_n, lat} = '0;
      hsize = 3'h2;
      master_slow_mode_pin = 1'b1;
      eeprom_addr_select_pins = 4'hA;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_good();
      t_sum();
      t_type2();
      t_faults();
      t_mode();
      conclude();
   end
endmodule
